/* File: bench/core_halt_run_handshake_chk.sv */
`timescale 1ns/100ps
module core_halt_run_handshake_chk (
  input wire clk, rst_n, cmd_stop, cmd_wake, cmd_dbg_stop, stop_ack, wake_ack, halt_status, dbg_stop_ack,
  input wire dbg_resume_ack, stop_req, wake_req, dbg_stop_req, dbg_resume_req, power_halted_state, debug_halted_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ======
  // Assertions
  reset_low_a: assert property ($rose(rst_n) |-> !(stop_req | wake_req | dbg_stop_req | dbg_resume_req))
    else $error("request high after reset");
  never_both_a: assert property (!(stop_req && wake_req))
    else $error("stop and wake together");
  stop_cause_a: assert property ($rose(stop_req) |-> $past(cmd_stop))
    else $error("stop without command");
  stop_drop_a: assert property (stop_req && stop_ack |-> ##[1:4] !stop_req)
    else $error("stop not dropped");
  wake_cause_a: assert property ($rose(wake_req) |-> $past(cmd_wake))
    else $error("wake without command");
  dstop_cause_a: assert property ($rose(dbg_stop_req) |-> $past(cmd_dbg_stop) && !dbg_stop_ack)
    else $error("debug stop bad start");
  dstop_drop_a: assert property (dbg_stop_req && dbg_stop_ack |-> ##[1:4] !dbg_stop_req)
    else $error("debug stop not dropped");
  dres_gate_a: assert property ($rose(dbg_resume_req) |-> $past(debug_halted_state))
    else $error("resume outside debug");
  dres_drop_a: assert property (dbg_resume_req && dbg_resume_ack |-> ##[1:4] !dbg_resume_req)
    else $error("resume not dropped");
  halt_seen_a: assert property (halt_status [*4] |-> power_halted_state)
    else $error("halt status not shown");
  cover property (stop_req && stop_ack);
  cover property (wake_req && wake_ack);
  cover property (dbg_stop_req && dbg_stop_ack);
  cover property (dbg_resume_req && dbg_resume_ack);
endmodule
bind core_halt_run_handshake core_halt_run_handshake_chk u_chk (.*);

/* File: bench/core_model.sv */
`timescale 1ns/100ps
`include "halt_run_defines.vh"
// ======
// Core side model, answers after lat cycles, mute withholds the stop ack
module core_model (
  input wire clk, rst_n, stop_req, wake_req, dbg_stop_req, dbg_resume_req, mute,
  input wire [3:0] lat,
  output logic stop_ack, wake_ack, halt_status, dbg_stop_ack, dbg_resume_ack, dbg_mode_status
);
  logic [3:0] cnt;
  logic [2:0] cause;
  logic [15:0] pc, dpc;
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      cnt <= 4'h0;
      cause <= 3'h0;
      pc <= 16'h0000;
      dpc <= 16'h0000;
      {stop_ack, wake_ack, halt_status, dbg_stop_ack, dbg_resume_ack, dbg_mode_status} <= 6'h00;
    end
    else
    begin
      cnt <= !(stop_req | wake_req | dbg_stop_req | dbg_resume_req) ? 4'h0 : cnt == lat ? cnt : cnt + 4'h1;
      pc <= (halt_status || dbg_mode_status) ? pc : pc + 16'h0001;
      if (!stop_req) stop_ack <= 1'b0;
      else if (cnt == lat && !dbg_mode_status && !mute) {halt_status, stop_ack} <= 2'h3;
      if (!wake_req) wake_ack <= 1'b0;
      else if (cnt == lat) {halt_status, wake_ack} <= 2'h1;
      if (!dbg_stop_req) dbg_stop_ack <= 1'b0;
      else if (cnt == lat)
      begin
        {dbg_mode_status, dbg_stop_ack} <= 2'h3;
        if (!dbg_mode_status)
        begin
          cause <= `DEBUG_CAUSE_HALT;
          dpc <= pc;
        end
      end
      if (!dbg_resume_req) dbg_resume_ack <= 1'b0;
      else if (cnt == lat && !halt_status) {dbg_mode_status, dbg_resume_ack} <= 2'h1;
    end
endmodule

/* File: bench/tb_core_halt_run_handshake.sv */
`timescale 1ns/100ps
`include "halt_run_defines.vh"
module tb_core_halt_run_handshake;
  logic clk = 0, rst_n = 0, pwr_enable = 1, dbg_enable = 1, cmd_stop = 0, cmd_wake = 0, cmd_dbg_stop = 0;
  logic cmd_dbg_resume = 0, mute = 0, to_exp = 0;
  logic [3:0] lat = 0;
  logic [1:0] st = 0;
  wire stop_ack, wake_ack, halt_status, dbg_stop_ack, dbg_resume_ack, dbg_mode_status, stop_req, wake_req;
  wire dbg_stop_req, dbg_resume_req, busy, power_halted_state, debug_halted_state, timeout;
  integer seed = 32'he7b6, n_errors = 0, checks_done = 0, i, k;
  always #12.5 clk = ~clk;
  core_halt_run_handshake #(.ACK_WAIT(16'h0040)) dut (.*);
  core_model core (.*);
  // ======
  // Checks and expectations
  task chk(input logic [3:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function logic [1:0] nxt(input logic [1:0] s, input logic [3:0] c);
    nxt = s;
    if (c[1]) nxt[1] = 1'b1;
    else if (c[0] && s[1]) nxt[1] = 1'b0;
    else if (c[3] && c[2]) nxt = s;
    else if (c[3] && s == 2'h0) nxt[0] = 1'b1;
    else if (c[2] && s == 2'h1) nxt[0] = 1'b0;
  endfunction
  task do_reset;
    rst_n = 0;
    repeat (8) @(posedge clk);
    #2 rst_n = 1;
    st = 2'h0;
    chk({stop_req, wake_req, dbg_stop_req, dbg_resume_req}, 4'h0);
    chk({timeout, busy, debug_halted_state, power_halted_state}, 4'h0);
  endtask
  task op(input logic [3:0] c);
    lat = 4'($random(seed));
    @(posedge clk);
    #2 {cmd_stop, cmd_wake, cmd_dbg_stop, cmd_dbg_resume} = c;
    @(posedge clk);
    #2 {cmd_stop, cmd_wake, cmd_dbg_stop, cmd_dbg_resume} = 4'h0;
    for (k = 0; busy !== 1'b0; k++)
    begin
      if (k > 200)
      begin
        n_errors++;
        close_out;
      end
      @(posedge clk);
      #2;
    end
    st = mute ? st : nxt(st, c);
    chk({timeout, 1'b0, debug_halted_state, power_halted_state}, {to_exp, 1'b0, st});
    if (st[1]) chk({1'b0, core.cause}, {1'b0, `DEBUG_CAUSE_HALT});
    $display("op %h done", c);
  endtask
  // ======
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    #2 rst_n = 1;
    chk({stop_req, wake_req, dbg_stop_req, dbg_resume_req}, 4'h0);
    op(4'hC);
    op(4'h1);
    op(4'h4);
    mute = 1;
    to_exp = 1;
    op(4'h8);
    mute = 0;
    to_exp = 0;
    op(4'h8);
    op(4'h4);
    op(4'h2);
    op(4'h2);
    op(4'h8);
    for (i = 0; i < 40; i++)
    begin
      if (st == 2'h3) do_reset;
      op(4'($random(seed)) & (st == 2'h3 ? 4'hE : 4'hF));
    end
    close_out;
  end
endmodule

/* File: common/halt_run_defines.vh */
`ifndef HALT_RUN_DEFINES_VH
`define HALT_RUN_DEFINES_VH
// Handshake engine states
`define HS_IDLE 2'h0
`define HS_REQ 2'h1
`define HS_DROP 2'h2
`define HS_DONE 2'h3
// Debug entry cause code written by the core on a debug stop
`define DEBUG_CAUSE_HALT 3'h3
// Default ack wait limit in cycles
`define ACK_WAIT_CYCLES 16'h0400
// Ack wait counter step and clear values
`define WAIT_STEP 16'h0001
`define WAIT_CLEAR 16'h0000
// Handshake engine indices
`define ENG_STOP 0
`define ENG_WAKE 1
`define ENG_DSTOP 2
`define ENG_DRES 3
`define NUM_ENG 4
// Synchronized input bit positions
`define SY_STOP_ACK 0
`define SY_WAKE_ACK 1
`define SY_HALT 2
`define SY_DSTOP_ACK 3
`define SY_DRES_ACK 4
`define SY_DMODE 5
`define NUM_SYNC 6
`endif

/* File: rtl/core_halt_run_handshake.v */
`timescale 1ns/100ps
// Overview of operation
// - All requests, acks and status are active high
// - Stop request raised to enter power halt
// - Drop stop request once ack seen
// - Unused power requests held low
// - Wake request four-phase handshake with core
// - Never raise stop and wake together
// - Avoid requesting current state; timeout recovers
// - Debug stop request, core acks after halting
// - Drop debug stop after ack; ack follows
// - No back-to-back debug stop requests; code starts one whenever both debug engines are idle, even if debug halted
// - Unused debug stop request held low
// - Debug resume request, core acks after resuming
// - Drop debug resume after ack; ack follows
// - Resume only while debug halted; wake pending stop
`include "halt_run_defines.vh"
module core_halt_run_handshake #(
  parameter [15:0] ACK_WAIT = `ACK_WAIT_CYCLES
)(
  input wire clk,
  input wire rst_n,
  input wire pwr_enable,
  input wire dbg_enable,
  input wire cmd_stop,
  input wire cmd_wake,
  input wire cmd_dbg_stop,
  input wire cmd_dbg_resume,
  input wire stop_ack,
  input wire wake_ack,
  input wire halt_status,
  input wire dbg_stop_ack,
  input wire dbg_resume_ack,
  input wire dbg_mode_status,
  output reg stop_req,
  output reg wake_req,
  output reg dbg_stop_req,
  output reg dbg_resume_req,
  output reg busy,
  output reg power_halted_state,
  output reg debug_halted_state,
  output reg timeout
);

// ==========================================
// Decode helpers
function is_req;
  input [1:0] s;
  begin
    is_req = (s == `HS_REQ);
  end
endfunction

function is_idle;
  input [1:0] s;
  begin
    is_idle = (s == `HS_IDLE);
  end
endfunction

// ==========================================
// Synchronizers
wire [`NUM_SYNC-1:0] async_in;
wire [`NUM_SYNC-1:0] sync_out;
assign async_in[`SY_STOP_ACK] = stop_ack;
assign async_in[`SY_WAKE_ACK] = wake_ack;
assign async_in[`SY_HALT] = halt_status;
assign async_in[`SY_DSTOP_ACK] = dbg_stop_ack;
assign async_in[`SY_DRES_ACK] = dbg_resume_ack;
assign async_in[`SY_DMODE] = dbg_mode_status;
genvar gi;
generate
  for (gi = 0; gi < `NUM_SYNC; gi = gi + 1)
  begin : g_sync
    reg ff1;
    reg ff2;
    always @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        ff1 <= 1'b0;
        ff2 <= 1'b0;
      end
      else
      begin
        ff1 <= async_in[gi];
        ff2 <= ff1;
      end
    end
    assign sync_out[gi] = ff2;
  end
endgenerate
wire s_stop_ack = sync_out[`SY_STOP_ACK];
wire s_wake_ack = sync_out[`SY_WAKE_ACK];
wire s_halt = sync_out[`SY_HALT];
wire s_dstop_ack = sync_out[`SY_DSTOP_ACK];
wire s_dres_ack = sync_out[`SY_DRES_ACK];
wire s_dmode = sync_out[`SY_DMODE];

// ==========================================
// Handshake engines: 0 stop, 1 wake, 2 debug stop, 3 debug resume
wire [2*`NUM_ENG-1:0] st_all;
wire [2*`NUM_ENG-1:0] next_all;
wire [1:0] st_stop = st_all[2*`ENG_STOP +: 2];
wire [1:0] st_wake = st_all[2*`ENG_WAKE +: 2];
wire [1:0] st_dstop = st_all[2*`ENG_DSTOP +: 2];
wire [1:0] st_dres = st_all[2*`ENG_DRES +: 2];
wire [1:0] next_stop = next_all[2*`ENG_STOP +: 2];
wire [1:0] next_wake = next_all[2*`ENG_WAKE +: 2];
wire [1:0] next_dstop = next_all[2*`ENG_DSTOP +: 2];
wire [1:0] next_dres = next_all[2*`ENG_DRES +: 2];
wire [`NUM_ENG-1:0] ackv;
wire [`NUM_ENG-1:0] abort;
reg [`NUM_ENG-1:0] start;
reg [15:0] wait_cnt;
reg stop_pending;
wire pwr_req_open = is_req(st_stop) || is_req(st_wake);
wire any_busy = !is_idle(st_stop) || !is_idle(st_wake) || !is_idle(st_dstop) || !is_idle(st_dres);
wire next_busy = !is_idle(next_stop) || !is_idle(next_wake) || !is_idle(next_dstop) || !is_idle(next_dres);
wire dbg_free = is_idle(st_dstop) && is_idle(st_dres);
wire wait_over = (wait_cnt == ACK_WAIT);
assign ackv[`ENG_STOP] = s_stop_ack;
assign ackv[`ENG_WAKE] = s_wake_ack;
assign ackv[`ENG_DSTOP] = s_dstop_ack;
assign ackv[`ENG_DRES] = s_dres_ack;
// Power requests give way to a timeout or a debug stop
assign abort[`ENG_STOP] = wait_over || dbg_stop_req;
assign abort[`ENG_WAKE] = wait_over || dbg_stop_req;
assign abort[`ENG_DSTOP] = 1'b0;
assign abort[`ENG_DRES] = 1'b0;

// Command acceptance, debug first
wire take_dstop = dbg_enable && cmd_dbg_stop && dbg_free;
wire take_dres = dbg_enable && cmd_dbg_resume && s_dmode && dbg_free;
wire pwr_ok = pwr_enable && !any_busy && !s_dmode;
wire take_stop = cmd_stop && !cmd_wake && !s_halt;
wire take_wake = cmd_wake && !cmd_stop && (s_halt || stop_pending);

always @*
begin
  start = {`NUM_ENG{1'b0}};
  if (take_dstop)
    start[`ENG_DSTOP] = 1'b1;
  else if (take_dres)
    start[`ENG_DRES] = 1'b1;
  else if (pwr_ok && take_stop)
    start[`ENG_STOP] = 1'b1;
  else if (pwr_ok && take_wake)
    start[`ENG_WAKE] = 1'b1;
end

genvar hi;
generate
  for (hi = 0; hi < `NUM_ENG; hi = hi + 1)
  begin : g_hs
    reg [1:0] cur;
    reg [1:0] nxt;
    always @*
    begin
      nxt = cur;
      case (cur)
        `HS_IDLE:
          if (start[hi])
            nxt = `HS_REQ;
        `HS_REQ:
          if (ackv[hi] || abort[hi])
            nxt = `HS_DROP;
        `HS_DROP:
          if (!ackv[hi])
            nxt = `HS_DONE;
        `HS_DONE:
          nxt = `HS_IDLE;
        default:
          nxt = `HS_IDLE;
      endcase
    end
    always @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        cur <= `HS_IDLE;
      else
        cur <= nxt;
    end
    assign st_all[2*hi +: 2] = cur;
    assign next_all[2*hi +: 2] = nxt;
  end
endgenerate

// ==========================================
// Requests to the core
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    stop_req <= 1'b0;
  end
  else
  begin
    stop_req <= is_req(next_stop);
  end
end

always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    wake_req <= 1'b0;
  end
  else
  begin
    wake_req <= is_req(next_wake);
  end
end

always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    dbg_stop_req <= 1'b0;
  end
  else
  begin
    dbg_stop_req <= is_req(next_dstop);
  end
end

always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    dbg_resume_req <= 1'b0;
  end
  else
  begin
    dbg_resume_req <= is_req(next_dres);
  end
end

// ==========================================
// Status
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    busy <= 1'b0;
  end
  else
  begin
    busy <= next_busy;
  end
end

always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    power_halted_state <= 1'b0;
  end
  else
  begin
    power_halted_state <= s_halt;
  end
end

always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    debug_halted_state <= 1'b0;
  end
  else
  begin
    debug_halted_state <= s_dmode;
  end
end

// ==========================================
// Pending stop, ack wait and timeout
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
    stop_pending <= 1'b0;
  else if (start[`ENG_STOP])
    stop_pending <= 1'b1;
  else if (st_wake == `HS_DONE || s_halt)
    stop_pending <= 1'b0;
end

always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
    wait_cnt <= `WAIT_CLEAR;
  else if (pwr_req_open && !wait_over)
    wait_cnt <= wait_cnt + `WAIT_STEP;
  else if (!pwr_req_open)
    wait_cnt <= `WAIT_CLEAR;
end

always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
    timeout <= 1'b0;
  else if (pwr_req_open && wait_over && !ackv[`ENG_STOP] && !ackv[`ENG_WAKE])
    timeout <= 1'b1;
  else if (start[`ENG_STOP] || start[`ENG_WAKE])
    timeout <= 1'b0;
end

endmodule
